// >>> pmu_irq_and_timer_clock_ctrl_tb.sv
// Self-checking bench for the always-on power-unit register block.
// Assumes pmuirq_pkg and pmuirq_ctrl are compiled first; the divider is shrunk to 8.
`timescale 1ns/1ps
module pmu_irq_and_timer_clock_ctrl_tb;
  import pmuirq_pkg::*;
  localparam int unsigned DIV = 8;
  localparam logic [31:0] UNMAPPED_ADDR = 32'h4003_8040;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic bus_sel_i = 1'b0;
  logic bus_write_i = 1'b0;
  logic [31:0] bus_addr_i = 32'h0;
  logic [31:0] bus_wdata_i = 32'h0;
  logic [31:0] bus_rdata_o;
  logic access_ready_o;
  logic [OSC_TRIM_W-1:0] osc_trim_boot_i = 6'h2a;
  logic [OSC_LEVEL_W-1:0] osc_level_boot_i = 2'h2;
  logic brownout_event_i = 1'b0;
  logic field_event_i = 1'b0;
  logic power_status_register_read_i = 1'b0;
  logic rtc_clock_en_o;
  logic [OSC_TRIM_W-1:0] osc_trim_value_o;
  logic [OSC_LEVEL_W-1:0] osc_current_level_o;
  logic irq_o;
  int bad_count = 0;
  int compares = 0;
  int n;

  always #2.5 mclk_i = ~mclk_i;

  pmuirq_ctrl #(.LFO_DIV(DIV)) uut (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .bus_sel_i(bus_sel_i),
    .bus_write_i(bus_write_i),
    .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o),
    .access_ready_o(access_ready_o),
    .osc_trim_boot_i(osc_trim_boot_i),
    .osc_level_boot_i(osc_level_boot_i),
    .brownout_event_i(brownout_event_i),
    .field_event_i(field_event_i),
    .power_status_register_read_i(power_status_register_read_i),
    .rtc_clock_en_o(rtc_clock_en_o),
    .osc_trim_value_o(osc_trim_value_o),
    .osc_current_level_o(osc_current_level_o),
    .irq_o(irq_o)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int i;
    @(negedge mclk_i);
    for (i = 0; i < 100 && access_ready_o !== 1'b1; i++)
      @(negedge mclk_i);
    chk(access_ready_o, 1'b1);
  endtask

  task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(posedge mclk_i);
    bus_sel_i <= 1'b1;
    bus_write_i <= wr;
    bus_addr_i <= addr;
    bus_wdata_i <= data;
    @(posedge mclk_i);
    bus_sel_i <= 1'b0;
  endtask

  task automatic cmd(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    access(wr, addr, data);
    @(negedge mclk_i);
    chk(access_ready_o, 1'b0);
    wait_ready();
  endtask

  // A read is a command followed by a re-read that must not start a new command.
  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    cmd(1'b0, addr, 32'h0);
    access(1'b0, addr, 32'h0);
    @(negedge mclk_i);
    chk(access_ready_o, 1'b1);
    chk(bus_rdata_o, exp);
  endtask

  task automatic pulse(input logic bo, input logic fd, input logic ps);
    @(posedge mclk_i);
    brownout_event_i <= bo;
    field_event_i <= fd;
    power_status_register_read_i <= ps;
    @(posedge mclk_i);
    brownout_event_i <= 1'b0;
    field_event_i <= 1'b0;
    power_status_register_read_i <= 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic count_ticks(output int k);
    k = 0;
    repeat (4 * DIV)
    begin
      @(negedge mclk_i);
      if (rtc_clock_en_o === 1'b1)
        k++;
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    @(negedge mclk_i);
    chk(osc_trim_value_o, 6'h2a);
    chk(osc_current_level_o, 2'h2);
    rd_chk(TIMER_CLOCK_CONTROL_ADDR, 32'h00aa_0001);
    count_ticks(n);
    chk(n, 4);
    cmd(1'b1, TIMER_CLOCK_CONTROL_ADDR, 32'h0055_0000);
    count_ticks(n);
    chk(n, 0);
    chk(osc_trim_value_o, 6'h15);
    chk(osc_current_level_o, 2'h1);
    rd_chk(TIMER_CLOCK_CONTROL_ADDR, 32'h0055_0000);
    cmd(1'b1, TIMER_CLOCK_CONTROL_ADDR, 32'h0055_0001);
    count_ticks(n);
    chk(n, 4);
    rd_chk(INTERRUPT_MASK_ADDR, 32'h0);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h0);
    pulse(1'b1, 1'b0, 1'b0);
    chk(irq_o, 1'b0);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h1);
    rd_chk(MASKED_INTERRUPT_STATUS_ADDR, 32'h0);
    cmd(1'b1, INTERRUPT_MASK_ADDR, 32'hffff_ffff);
    chk(irq_o, 1'b1);
    rd_chk(INTERRUPT_MASK_ADDR, 32'h3);
    rd_chk(MASKED_INTERRUPT_STATUS_ADDR, 32'h1);
    pulse(1'b0, 1'b1, 1'b0);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h3);
    rd_chk(MASKED_INTERRUPT_STATUS_ADDR, 32'h3);
    cmd(1'b1, INTERRUPT_CLEAR_ADDR, 32'h1);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h2);
    cmd(1'b1, INTERRUPT_CLEAR_ADDR, 32'h2);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h0);
    chk(irq_o, 1'b0);
    pulse(1'b1, 1'b1, 1'b0);
    cmd(1'b1, INTERRUPT_CLEAR_ADDR, 32'h3);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h0);
    pulse(1'b1, 1'b1, 1'b0);
    pulse(1'b0, 1'b0, 1'b1);
    chk(irq_o, 1'b0);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h0);
    pulse(1'b1, 1'b0, 1'b0);
    access(1'b1, RAW_INTERRUPT_STATUS_ADDR, 32'h0);
    wait_ready();
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h1);
    rd_chk(INTERRUPT_CLEAR_ADDR, 32'h0);
    rd_chk(UNMAPPED_ADDR, 32'h0);
    cmd(1'b1, INTERRUPT_MASK_ADDR, 32'h0);
    chk(irq_o, 1'b0);
    rd_chk(RAW_INTERRUPT_STATUS_ADDR, 32'h1);
    test_done();
  end
endmodule

// >>> pmuirq_ctrl.sv
// Always-on power-unit register block: timer clock control and two-source interrupt logic.
// Assumes bus inputs are synchronous to mclk_i and software waits for access_ready_o.
`timescale 1ns/1ps
module pmuirq_ctrl
  import pmuirq_pkg::*;
#(
  parameter int unsigned LFO_DIV = LFO_DIV_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic bus_sel_i,
  input wire logic bus_write_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  output logic access_ready_o,
  input wire logic [OSC_TRIM_W-1:0] osc_trim_boot_i,
  input wire logic [OSC_LEVEL_W-1:0] osc_level_boot_i,
  input wire logic brownout_event_i,
  input wire logic field_event_i,
  input wire logic power_status_register_read_i,
  output logic rtc_clock_en_o,
  output logic [OSC_TRIM_W-1:0] osc_trim_value_o,
  output logic [OSC_LEVEL_W-1:0] osc_current_level_o,
  output logic irq_o
);
  logic lfo_tick;
  pmuirq_cmd_state_t state_r;
  pmuirq_cmd_state_t state_nxt;
  pmuirq_cmd_buf_t buf_r;
  pmuirq_cmd_buf_t buf_nxt;
  logic [31:0] rdata_nxt;
  logic ready_nxt;
  logic boot_done_r;
  logic boot_done_nxt;
  logic rtc_clock_select_r;
  logic rtc_clock_select_nxt;
  logic [OSC_TRIM_W-1:0] trim_nxt;
  logic [OSC_LEVEL_W-1:0] level_nxt;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] mask_nxt;
  logic [IRQ_W-1:0] pend_r;
  logic [IRQ_W-1:0] pend_nxt;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] events;
  logic rtc_nxt;
  logic irq_nxt;
  logic take;
  logic reread;
  logic exec;
  logic exec_wr;
  logic [31:0] reg_view;

  pmuirq_lfo_div #(
    .DIV(LFO_DIV)
  ) u_lfo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_o(lfo_tick)
  );

  assign events = {field_event_i, brownout_event_i};

  always_comb
  begin
    reg_view = 32'h0000_0000;
    if (buf_r.addr == TIMER_CLOCK_CONTROL_ADDR)
    begin
      reg_view[RTC_CLOCK_SELECT_POS] = rtc_clock_select_r;
      reg_view[OSC_TRIM_LSB +: OSC_TRIM_W] = osc_trim_value_o;
      reg_view[OSC_LEVEL_LSB +: OSC_LEVEL_W] = osc_current_level_o;
    end
    else if (buf_r.addr == INTERRUPT_MASK_ADDR)
    begin
      reg_view[IRQ_W-1:0] = mask_r;
    end
    else if (buf_r.addr == RAW_INTERRUPT_STATUS_ADDR)
    begin
      reg_view[IRQ_W-1:0] = pend_r;
    end
    else if (buf_r.addr == MASKED_INTERRUPT_STATUS_ADDR)
    begin
      reg_view[IRQ_W-1:0] = pend_r & mask_r;
    end
  end

  // command buffer synchronised to the oscillator tick
  always_comb
  begin
    state_nxt = state_r;
    buf_nxt = buf_r;
    rdata_nxt = bus_rdata_o;
    take = 1'b0;
    reread = 1'b0;
    exec = 1'b0;
    if (state_r == CMD_IDLE && bus_sel_i)
    begin
      // A matching re-read is served from the buffer and ends the match, so a third read runs anew.
      if (!bus_write_i && buf_r.addr_valid && !buf_r.is_write && bus_addr_i == buf_r.addr)
      begin
        reread = 1'b1;
        rdata_nxt = buf_r.data;
        buf_nxt.addr_valid = 1'b0;
      end
      else
      begin
        take = 1'b1;
        buf_nxt.addr = bus_addr_i;
        buf_nxt.data = bus_wdata_i;
        buf_nxt.is_write = bus_write_i;
        buf_nxt.addr_valid = 1'b1;
        state_nxt = CMD_WAIT;
      end
    end
    else if (state_r == CMD_WAIT && lfo_tick)
    begin
      exec = 1'b1;
      if (!buf_r.is_write)
      begin
        buf_nxt.data = reg_view;
      end
      state_nxt = CMD_DONE;
    end
    else if (state_r == CMD_DONE && lfo_tick)
    begin
      state_nxt = CMD_IDLE;
    end
    ready_nxt = (state_nxt == CMD_IDLE);
  end

  assign exec_wr = exec && buf_r.is_write;

  // Register updates: bus writes act on the tick; boot load, events and the status-read clear act on any cycle.
  always_comb
  begin
    boot_done_nxt = 1'b1;
    rtc_clock_select_nxt = rtc_clock_select_r;
    trim_nxt = osc_trim_value_o;
    level_nxt = osc_current_level_o;
    mask_nxt = mask_r;
    clr = {IRQ_W{1'b0}};
    // device value caught after reset release
    if (!boot_done_r)
    begin
      trim_nxt = osc_trim_boot_i;
      level_nxt = osc_level_boot_i;
    end
    if (exec_wr && buf_r.addr == TIMER_CLOCK_CONTROL_ADDR)
    begin
      rtc_clock_select_nxt = buf_r.data[RTC_CLOCK_SELECT_POS];
      trim_nxt = buf_r.data[OSC_TRIM_LSB +: OSC_TRIM_W];
      level_nxt = buf_r.data[OSC_LEVEL_LSB +: OSC_LEVEL_W];
    end
    else if (exec_wr && buf_r.addr == INTERRUPT_MASK_ADDR)
    begin
      mask_nxt = buf_r.data[IRQ_W-1:0];
    end
    // write-one clear of all selected bits
    else if (exec_wr && buf_r.addr == INTERRUPT_CLEAR_ADDR)
    begin
      clr = buf_r.data[IRQ_W-1:0];
    end
    if (power_status_register_read_i)
    begin
      clr = {IRQ_W{1'b1}};
    end
    // Set wins over clear so an event in the clearing cycle is kept.
    pend_nxt = (pend_r & ~clr) | events;
    rtc_nxt = lfo_tick && rtc_clock_select_r;
    irq_nxt = |(pend_nxt & mask_nxt);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= CMD_IDLE;
      buf_r <= '0;
      bus_rdata_o <= 32'h0000_0000;
      access_ready_o <= ACCESS_READY_RST;
      boot_done_r <= 1'b0;
      rtc_clock_select_r <= RTC_CLOCK_SELECT_RST;
      osc_trim_value_o <= '0;
      osc_current_level_o <= '0;
      mask_r <= MASK_RST;
      pend_r <= PENDING_RST;
      rtc_clock_en_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      buf_r <= buf_nxt;
      bus_rdata_o <= rdata_nxt;
      access_ready_o <= ready_nxt;
      boot_done_r <= boot_done_nxt;
      rtc_clock_select_r <= rtc_clock_select_nxt;
      osc_trim_value_o <= trim_nxt;
      osc_current_level_o <= level_nxt;
      mask_r <= mask_nxt;
      pend_r <= pend_nxt;
      rtc_clock_en_o <= rtc_nxt;
      irq_o <= irq_nxt;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_rtc_gate: assert property (rtc_clock_en_o
    |-> $past(lfo_tick) && $past(rtc_clock_select_r))
    else $error("rtc clock enable without tick or select");
  a_rtc_stops: assert property (!rtc_clock_select_r |=> !rtc_clock_en_o)
    else $error("rtc clock enable while deselected");

  a_boot_trim: assert property (!boot_done_r
    |=> osc_trim_value_o == $past(osc_trim_boot_i)
    && osc_current_level_o == $past(osc_level_boot_i))
    else $error("boot trim or current level not taken");
  a_trim_write: assert property (exec_wr && buf_r.addr == TIMER_CLOCK_CONTROL_ADDR
    |=> osc_trim_value_o == $past(buf_r.data[OSC_TRIM_LSB +: OSC_TRIM_W])
    && osc_current_level_o == $past(buf_r.data[OSC_LEVEL_LSB +: OSC_LEVEL_W]))
    else $error("trim or current level not written");
  a_mask_write: assert property (exec_wr && buf_r.addr == INTERRUPT_MASK_ADDR
    |=> mask_r == $past(buf_r.data[IRQ_W-1:0]))
    else $error("mask not written");

  a_event_sets: assert property (brownout_event_i |=> pend_r[BROWNOUT_POS])
    else $error("brown-out event lost");
  a_field_sets: assert property (field_event_i |=> pend_r[FIELD_POS])
    else $error("field-detect event lost");
  a_status_read_only: assert property (exec_wr && buf_r.addr == RAW_INTERRUPT_STATUS_ADDR
    && !power_status_register_read_i && events == 2'h0 |=> pend_r == $past(pend_r))
    else $error("raw status changed by a write");
  a_ris_read: assert property (exec && !buf_r.is_write
    && buf_r.addr == RAW_INTERRUPT_STATUS_ADDR
    |=> buf_r.data == {{(32-IRQ_W){1'b0}}, $past(pend_r)})
    else $error("raw status read wrong");
  a_mis_read: assert property (exec && !buf_r.is_write
    && buf_r.addr == MASKED_INTERRUPT_STATUS_ADDR
    |=> buf_r.data == {{(32-IRQ_W){1'b0}}, $past(pend_r & mask_r)})
    else $error("masked status read wrong");

  a_clear_brownout: assert property (exec_wr && buf_r.addr == INTERRUPT_CLEAR_ADDR
    && buf_r.data[BROWNOUT_POS] && !brownout_event_i |=> !pend_r[BROWNOUT_POS])
    else $error("brown-out clear write ignored");
  a_clear_field: assert property (exec_wr && buf_r.addr == INTERRUPT_CLEAR_ADDR
    && buf_r.data[FIELD_POS] && !field_event_i |=> !pend_r[FIELD_POS])
    else $error("field-detect clear write ignored");
  a_clear_bits: assert property (exec_wr && buf_r.addr == INTERRUPT_CLEAR_ADDR
    && (buf_r.data[1:0] == 2'h3) && !power_status_register_read_i && events == 2'h0 |=> pend_r == 2'h0)
    else $error("clear write did not clear both");
  a_clear_read: assert property (exec && !buf_r.is_write
    && buf_r.addr == INTERRUPT_CLEAR_ADDR |=> buf_r.data == 32'h0000_0000)
    else $error("clear register read not zero");
  a_power_status_register_clear: assert property (power_status_register_read_i && events == 2'h0 |=> pend_r == 2'h0)
    else $error("power status read did not clear");

  a_ready_drop: assert property (take |=> !access_ready_o ##1 !access_ready_o)
    else $error("ready did not drop on new command");
  a_busy_hold: assert property (state_r != CMD_IDLE
    |=> buf_r.addr == $past(buf_r.addr) && buf_r.is_write == $past(buf_r.is_write))
    else $error("buffered request changed while busy");
  a_ready_return: assert property (state_r == CMD_DONE && lfo_tick |=> access_ready_o)
    else $error("ready did not return after command");
  a_reread_data: assert property (reread
    |=> bus_rdata_o == $past(buf_r.data) && access_ready_o)
    else $error("re-read data wrong");

  a_irq_level: assert property (irq_o == |(pend_r & mask_r))
    else $error("irq differs from masked status");

  // Main scenarios: write command, re-read, interrupt, set against clear, third read.
  c_write_cmd: cover property (take && bus_write_i ##[1:20] !access_ready_o);
  c_reread: cover property (reread);
  c_irq: cover property (irq_o && !mask_r[0]);
  c_set_clear: cover property (power_status_register_read_i && brownout_event_i);
  c_third_read: cover property (take && !bus_write_i && bus_addr_i == buf_r.addr);
endmodule

// >>> pmuirq_lfo_div.sv
// Free-running divider that models the slow oscillator as a one-cycle tick.
// Assumes the always-on supply is present whenever the clock runs.
`timescale 1ns/1ps
module pmuirq_lfo_div
  import pmuirq_pkg::*;
#(
  parameter int unsigned DIV = LFO_DIV_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic tick_nxt;

  always_comb
  begin
    tick_nxt = (cnt_r == 16'(DIV - 1));
    cnt_nxt = tick_nxt ? 16'h0000 : cnt_r + 16'h0001;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_tick_spacing: assert property (tick_o |=> !tick_o)
    else $error("oscillator ticks too close together");
  a_tick_recurs: assert property (cnt_r == 16'(DIV - 1) |=> tick_o)
    else $error("oscillator tick missing at end of period");
endmodule

// >>> pmuirq_pkg.sv
// Package for the always-on power-unit register block: offsets, fields, reset values, timing.
// Assumes a single 200 MHz system clock and a free-running slow oscillator tick.
// Overview of operation
// - Clock-select bit 0 gates the real-time clock, 0 gives no clock, 1 the 32 kHz oscillator, and it reads 1 after boot.
// - Bits 21:16 of the timer clock control register hold the 6-bit oscillator trim, loaded per device at boot.
// - Bits 23:22 of the timer clock control register select the oscillator current level, loaded per device at boot.
// - The 32 kHz oscillator runs whenever the always-on supply is present and no setting stops it.
// - Mask bit 0 enables brown-out interrupt signalling when set and resets to 0.
// - Mask bit 1 enables field-detect interrupt signalling when set and resets to 0.
// - The raw status register is read-only and shows each pending condition regardless of the mask.
// - In both status registers bit 0 is brown-out and bit 1 is field detect, reset 0, bits 31:2 read 0.
// - The masked status register is read-only and equals raw status ANDed with the mask.
// - Writing 1 to clear bit 0 clears the pending brown-out condition.
// - Writing 1 to clear bit 1 clears the pending field-detect condition.
// - The clear register is write-only and one write clears every selected condition at once.
// - A read of the power status register also clears both pending conditions.
// - Accesses are carried out on the slow oscillator tick and software waits for the ready flag before a new one.
package pmuirq_pkg;
  localparam logic [31:0] TIMER_CLOCK_CONTROL_ADDR = 32'h4003_802c;
  localparam logic [31:0] INTERRUPT_MASK_ADDR = 32'h4003_8030;
  localparam logic [31:0] RAW_INTERRUPT_STATUS_ADDR = 32'h4003_8034;
  localparam logic [31:0] MASKED_INTERRUPT_STATUS_ADDR = 32'h4003_8038;
  localparam logic [31:0] INTERRUPT_CLEAR_ADDR = 32'h4003_803c;

  localparam int RTC_CLOCK_SELECT_POS = 0;
  localparam int OSC_TRIM_LSB = 16;
  localparam int OSC_TRIM_W = 6;
  localparam int OSC_LEVEL_LSB = 22;
  localparam int OSC_LEVEL_W = 2;
  localparam int BROWNOUT_POS = 0;
  localparam int FIELD_POS = 1;
  localparam int IRQ_W = 2;

  localparam logic RTC_CLOCK_SELECT_RST = 1'h1;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;
  localparam logic [IRQ_W-1:0] PENDING_RST = 2'h0;
  localparam logic ACCESS_READY_RST = 1'h1;

  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned LFO_HZ = 32_000;
  localparam int unsigned LFO_DIV_CYCLES = int'(CLK_HZ / LFO_HZ);

  typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT, CMD_DONE} pmuirq_cmd_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic is_write;
    logic addr_valid;
  } pmuirq_cmd_buf_t;
endpackage
